// *** hdl/crs_pkg.sv ***
// constants and types shared by the cpu register set and condition code logic
// Notes on behaviour
// RULE_01: program counter is a 16-bit register holding the current instruction location.
// RULE_02: accumulator is 16 bits; byte operations use only its low byte.
// RULE_03: 16-bit second operand register feeds arithmetic with the accumulator.
// RULE_04: 16-bit index register modifies effective addresses in indexed addressing.
// RULE_05: 16-bit extra pointer register directly designates a memory address.
// RULE_06: 16-bit stack pointer designates the current stack location.
// RULE_07: status word: upper byte bank pointer, lower byte condition codes.
// RULE_08: half-carry set on carry or borrow between bits 3 and 4.
// RULE_09: interrupt enable 1 permits, 0 blocks; reset clears it.
// RULE_10: two-bit level mask admits only higher priority; value 3 admits none. The code admits levels below the mask: 3 admits 0 to 2, 0 admits none.
// RULE_11: negative flag copies the result's most significant bit.
// RULE_12: zero flag set for a zero result, cleared otherwise.
// RULE_13: overflow flag set on two's complement overflow, cleared otherwise.
// RULE_14: carry flag set on carry or borrow out of bit 7.
// RULE_15: shifts load the carry flag with the shifted-out bit.
// RULE_16: general registers are bytes in data memory, eight per bank.
// RULE_17: usable banks depend on ram size: 16 small, 32 large.
// RULE_18: bank pointer selects the bank and converts to its memory address.
// RULE_19: one 64 KB space: I/O lowest, data directly above.
// RULE_20: program area at the top; reset and interrupt vectors fetched there.
// RULE_21: bank base is bank number times eight plus a ram base.
// RULE_22: unaffected flags hold; all flags writable together via the status word.
package crs_pkg;

    // register select codes, shared by datapath and bus; byte offset is code times four
    localparam logic [2:0]  CRS_SEL_PC      = 3'h0;
    localparam logic [2:0]  CRS_SEL_ACC     = 3'h1;
    localparam logic [2:0]  CRS_SEL_TMP     = 3'h2;
    localparam logic [2:0]  CRS_SEL_IX      = 3'h3;
    localparam logic [2:0]  CRS_SEL_EP      = 3'h4;
    localparam logic [2:0]  CRS_SEL_SP      = 3'h5;
    localparam logic [2:0]  CRS_SEL_PSW     = 3'h6;
    localparam logic [2:0]  CRS_SEL_STATUS  = 3'h7;
    localparam int          CRS_NUM_REGS    = 7;

    // bus byte offsets
    localparam logic [31:0] CRS_OFF_PC      = 32'h0000_0000;
    localparam logic [31:0] CRS_OFF_STATUS  = 32'h0000_001C;

    // condition code bit positions inside the low byte of the status word
    localparam int          CRS_BIT_C       = 0;
    localparam int          CRS_BIT_V       = 1;
    localparam int          CRS_BIT_Z       = 2;
    localparam int          CRS_BIT_N       = 3;
    localparam int          CRS_BIT_IL0     = 4;
    localparam int          CRS_BIT_IL1     = 5;
    localparam int          CRS_BIT_I       = 6;
    localparam int          CRS_BIT_H       = 7;

    // flag update mask positions
    localparam int          CRS_FWE_C       = 0;
    localparam int          CRS_FWE_V       = 1;
    localparam int          CRS_FWE_Z       = 2;
    localparam int          CRS_FWE_N       = 3;
    localparam int          CRS_FWE_H       = 4;

    // reset values
    localparam logic [15:0] CRS_RST_REG     = 16'h0000;
    localparam logic [15:0] CRS_RST_PSW     = 16'h0030;
    localparam logic [31:0] CRS_RST_RDATA   = 32'h0000_0000;

    // memory map
    localparam logic [15:0] CRS_IO_TOP      = 16'h007F;
    localparam logic [15:0] CRS_DATA_TOP    = 16'h027F;
    localparam logic [15:0] CRS_PROG_BASE   = 16'hC000;
    localparam logic [15:0] CRS_RAM_BASE    = 16'h0100;
    localparam logic [15:0] CRS_RESET_VEC   = 16'hFFFE;
    localparam logic [15:0] CRS_IRQ_VEC     = 16'hFFF8;

    // register banks
    localparam int          CRS_BANK_REGS   = 8;
    localparam logic [4:0]  CRS_BANKS_SMALL = 5'h0F;
    localparam logic [4:0]  CRS_BANKS_LARGE = 5'h1F;

    typedef enum logic [2:0] {
        CRS_ALU_NONE,
        CRS_ALU_ADD,
        CRS_ALU_SUB,
        CRS_ALU_SHL,
        CRS_ALU_SHR
    } crs_alu_op_t;

    typedef enum logic [1:0] {
        CRS_AREA_IO,
        CRS_AREA_DATA,
        CRS_AREA_PROG,
        CRS_AREA_GAP
    } crs_area_t;

endpackage : crs_pkg

// *** hdl/crs_register_set.sv ***
// cpu dedicated registers, condition codes and an ahb-lite register window
`timescale 1ns/1ps
module crs_register_set
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    // ahb-lite slave
    input  wire logic               hsel_in,
    input  wire logic [31:0]        haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [31:0]        hwdata_in,
    input  wire logic               hready_in,
    output logic      [31:0]        hrdata_out,
    output logic                    hreadyout_out,
    output logic                    hresp_out,
    // datapath register write
    input  wire logic               dp_wr_en_in,
    input  wire logic [2:0]         dp_wr_sel_in,
    input  wire logic               dp_wr_byte_in,
    input  wire logic [15:0]        dp_wr_data_in,
    // datapath arithmetic
    input  wire crs_alu_op_t        alu_op_in,
    input  wire logic               alu_carry_in_in,
    input  wire logic [4:0]         alu_flag_we_in,
    // interrupt request
    input  wire logic               irq_valid_in,
    input  wire logic [1:0]         irq_level_in,
    // memory and bank addressing
    input  wire logic [15:0]        mem_addr_in,
    input  wire logic [2:0]         gpr_index_in,
    input  wire logic               ram_large_in,
    // register contents
    output logic      [15:0]        program_counter_out,
    output logic      [15:0]        sum_word_out,
    output logic      [15:0]        second_operand_out,
    output logic      [15:0]        index_register_out,
    output logic      [15:0]        extra_pointer_out,
    output logic      [15:0]        stack_pointer_out,
    output logic      [15:0]        program_status_word_out,
    // derived state
    output logic                    irq_accept_out,
    output logic      [15:0]        gpr_addr_out,
    output crs_area_t               mem_area_out,
    output logic      [15:0]        vector_addr_out
);

    // returns {valid, select} for a bus byte address
    function automatic logic [3:0] crs_decode(input logic [31:0] addr);
        logic ok;
        ok = (addr[31:5] == 27'h000_0000) && (addr[1:0] == 2'h0);
        crs_decode = {ok, addr[4:2]};
    endfunction : crs_decode

    logic [15:0]    regs [0:CRS_NUM_REGS-1];
    logic [15:0]    next_reg [0:CRS_NUM_REGS-1];
    logic           wr_pend;
    logic [2:0]     wr_sel;

    // ---------------- bus slave ----------------
    wire            bus_take    = hsel_in && htrans_in[1] && hready_in;
    wire  [3:0]     dec_now     = crs_decode(haddr_in);
    wire            size_word   = (hsize_in == 3'h2);
    wire            dec_reg     = dec_now[3] && (dec_now[2:0] != CRS_SEL_STATUS);
    wire            take_write  = bus_take && hwrite_in && size_word && dec_reg;
    wire            take_read   = bus_take && !hwrite_in;
    wire  [2:0]     rd_sel      = dec_now[2:0];
    wire  [15:0]    rd_reg      = regs[rd_sel];
    wire  [31:0]    status_word = {gpr_addr_out, 13'h0000, irq_accept_out, mem_area_out};
    wire  [31:0]    read_word   = !dec_now[3] ? CRS_RST_RDATA
                                : (rd_sel == CRS_SEL_STATUS) ? status_word
                                : {16'h0000, rd_reg};

    // zero wait states; read data sampled at the address phase, so a read
    // issued while a write's data phase is still open would see the old value
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            wr_pend <= 1'b0;
            wr_sel  <= CRS_SEL_PC;
        end
        else if (hready_in)
        begin
            wr_pend <= take_write;
            wr_sel  <= dec_now[2:0];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            hrdata_out <= CRS_RST_RDATA;
        end
        else if (take_read)
        begin
            hrdata_out <= read_word;
        end
    end

    // never stalls and never errors, so both keep their reset level
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // ---------------- arithmetic and flags ----------------
    wire  [15:0]    psw         = regs[CRS_SEL_PSW];
    wire  [7:0]     op_a        = regs[CRS_SEL_ACC][7:0];   // RULE_02
    wire  [7:0]     op_b        = regs[CRS_SEL_TMP][7:0];   // RULE_03
    wire            carry_old   = psw[CRS_BIT_C];
    wire            cin         = alu_carry_in_in && carry_old;
    wire            is_add      = (alu_op_in == CRS_ALU_ADD);
    wire            is_sub      = (alu_op_in == CRS_ALU_SUB);
    wire            is_shl      = (alu_op_in == CRS_ALU_SHL);
    wire            is_shr      = (alu_op_in == CRS_ALU_SHR);
    wire            alu_active  = is_add || is_sub || is_shl || is_shr;
    wire  [8:0]     add_full    = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
    wire  [8:0]     sub_full    = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
    wire  [4:0]     add_low     = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
    wire  [4:0]     sub_low     = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};

    // shifts rotate through the carry so multi-byte shifts chain
    wire  [7:0]     alu_res     = is_add ? add_full[7:0]
                                : is_sub ? sub_full[7:0]
                                : is_shl ? {op_a[6:0], carry_old}
                                : {carry_old, op_a[7:1]};
    wire            c_new       = is_add ? add_full[8]      // RULE_14
                                : is_sub ? sub_full[8]
                                : is_shl ? op_a[7]          // RULE_15
                                : op_a[0];
    wire            h_new       = is_add ? add_low[4]       // RULE_08
                                : is_sub ? sub_low[4]
                                : psw[CRS_BIT_H];
    wire            v_add       = (op_a[7] == op_b[7]) && (alu_res[7] != op_a[7]);
    wire            v_sub       = (op_a[7] != op_b[7]) && (alu_res[7] != op_a[7]);
    wire            v_new       = is_add ? v_add            // RULE_13
                                : is_sub ? v_sub
                                : psw[CRS_BIT_V];
    wire            n_new       = alu_res[7];               // RULE_11
    wire            z_new       = (alu_res == 8'h00);       // RULE_12

    // flags outside the update mask keep their value
    wire  [7:0]     ccr_alu     = {                         // RULE_22
        alu_flag_we_in[CRS_FWE_H] ? h_new : psw[CRS_BIT_H],
        psw[CRS_BIT_I],
        psw[CRS_BIT_IL1],
        psw[CRS_BIT_IL0],
        alu_flag_we_in[CRS_FWE_N] ? n_new : psw[CRS_BIT_N],
        alu_flag_we_in[CRS_FWE_Z] ? z_new : psw[CRS_BIT_Z],
        alu_flag_we_in[CRS_FWE_V] ? v_new : psw[CRS_BIT_V],
        alu_flag_we_in[CRS_FWE_C] ? c_new : psw[CRS_BIT_C]
    };

    // ---------------- register update ----------------
    // datapath write beats arithmetic, which beats a bus write
    genvar gi;
    generate
        for (gi = 0; gi < CRS_NUM_REGS; gi++)
        begin : g_reg
            wire         dp_hit  = dp_wr_en_in && (dp_wr_sel_in == 3'(gi));
            wire         bus_hit = wr_pend && (wr_sel == 3'(gi));
            wire  [15:0] dp_val  = dp_wr_byte_in ? {regs[gi][15:8], dp_wr_data_in[7:0]}
                                                 : dp_wr_data_in;  // RULE_02
            wire  [15:0] alu_val;
            wire         alu_hit;
            if (gi == CRS_SEL_ACC)
            begin : g_acc
                assign alu_val = {regs[gi][15:8], alu_res};          // RULE_02
                assign alu_hit = alu_active;
            end
            else if (gi == CRS_SEL_PSW)
            begin : g_psw
                assign alu_val = {regs[gi][15:8], ccr_alu};          // RULE_07
                assign alu_hit = alu_active;
            end
            else
            begin : g_plain
                assign alu_val = regs[gi];
                assign alu_hit = 1'b0;
            end
            assign next_reg[gi] = dp_hit  ? dp_val
                                : alu_hit ? alu_val
                                : bus_hit ? hwdata_in[15:0]        // RULE_22
                                : regs[gi];

            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    regs[gi] <= (gi == CRS_SEL_PSW) ? CRS_RST_PSW : CRS_RST_REG; // RULE_09
                end
                else
                begin
                    regs[gi] <= next_reg[gi];
                end
            end
        end
    endgenerate

    assign program_counter_out     = regs[CRS_SEL_PC];    // RULE_01
    assign sum_word_out            = regs[CRS_SEL_ACC];
    assign second_operand_out      = regs[CRS_SEL_TMP];   // RULE_03
    assign index_register_out      = regs[CRS_SEL_IX];    // RULE_04
    assign extra_pointer_out       = regs[CRS_SEL_EP];    // RULE_05
    assign stack_pointer_out       = regs[CRS_SEL_SP];    // RULE_06
    assign program_status_word_out = regs[CRS_SEL_PSW];   // RULE_07

    // ---------------- interrupt gate, banks, map ----------------
    wire  [1:0]     il_mask     = {psw[CRS_BIT_IL1], psw[CRS_BIT_IL0]};
    wire            next_accept = irq_valid_in && psw[CRS_BIT_I]  // RULE_09
                                && (irq_level_in < il_mask);      // RULE_10

    // bank number wraps at the usable bank count of the ram size
    wire  [4:0]     bank_mask   = ram_large_in ? CRS_BANKS_LARGE : CRS_BANKS_SMALL; // RULE_17
    wire  [4:0]     bank_num    = psw[12:8] & bank_mask;                            // RULE_18
    wire  [15:0]    next_gpr    = CRS_RAM_BASE                                      // RULE_21
                                + {8'h00, bank_num, 3'h0}                           // RULE_16
                                + {13'h0000, gpr_index_in};

    crs_area_t next_area;
    assign next_area = (mem_addr_in <= CRS_IO_TOP)    ? CRS_AREA_IO     // RULE_19
                     : (mem_addr_in <= CRS_DATA_TOP)  ? CRS_AREA_DATA
                     : (mem_addr_in >= CRS_PROG_BASE) ? CRS_AREA_PROG   // RULE_20
                     : CRS_AREA_GAP;

    // vectors at the top of program space; accepted level picks its slot
    wire  [15:0]    next_vector = next_accept ? (CRS_IRQ_VEC + {13'h0000, irq_level_in, 1'b0})
                                : vector_addr_out;                      // RULE_20

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            irq_accept_out <= 1'b0;
        end
        else
        begin
            irq_accept_out <= next_accept;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            gpr_addr_out <= CRS_RAM_BASE;
        end
        else
        begin
            gpr_addr_out <= next_gpr;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            mem_area_out <= CRS_AREA_IO;
        end
        else
        begin
            mem_area_out <= next_area;
        end
    end

    // holds the last accepted slot so a late reader still finds it
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            vector_addr_out <= CRS_RESET_VEC;
        end
        else
        begin
            vector_addr_out <= next_vector;
        end
    end

endmodule : crs_register_set

// *** tb/crs_register_set_checker.sv ***
// concurrent checks on the register set ports
`timescale 1ns/1ps
module crs_register_set_checker
    import crs_pkg::*;
(
    // clock, reset and datapath side
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         dp_wr_en_in,
    input  wire logic [2:0]   dp_wr_sel_in,
    input  wire logic         dp_wr_byte_in,
    input  wire crs_alu_op_t  alu_op_in,
    input  wire logic [4:0]   alu_flag_we_in,
    input  wire logic         irq_valid_in,
    input  wire logic [1:0]   irq_level_in,
    input  wire logic [15:0]  mem_addr_in,
    input  wire logic [2:0]   gpr_index_in,
    input  wire logic         ram_large_in,
    // watched outputs
    input  wire logic [15:0]  sum_word_out,
    input  wire logic [15:0]  program_status_word_out,
    input  wire logic         irq_accept_out,
    input  wire logic [15:0]  gpr_addr_out,
    input  wire crs_area_t    mem_area_out,
    input  wire logic [15:0]  vector_addr_out
);
    wire logic [15:0] psw  = program_status_word_out;
    wire logic [4:0]  bank = ram_large_in ? psw[12:8] : {1'b0, psw[11:8]};
    wire logic        admit = irq_valid_in & psw[CRS_BIT_I] & (irq_level_in < psw[5:4]);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence alu_full_s;
        !dp_wr_en_in && alu_op_in != CRS_ALU_NONE && alu_flag_we_in == 5'h1F;
    endsequence
    sequence alu_hold_s;
        !dp_wr_en_in && alu_op_in != CRS_ALU_NONE && alu_flag_we_in == 5'h00;
    endsequence
    sequence shl_s;
        !dp_wr_en_in && alu_op_in == CRS_ALU_SHL && alu_flag_we_in[CRS_FWE_C];
    endsequence

    reset_status_a: assert property ($rose(reset_n_in) |-> psw == CRS_RST_PSW
        && vector_addr_out == CRS_RESET_VEC && gpr_addr_out == CRS_RAM_BASE)
        else $error("status word not at reset value");
    irq_admit_a: assert property ($past(reset_n_in) |-> irq_accept_out == $past(admit))
        else $error("interrupt acceptance wrong");
    level_none_a: assert property (irq_valid_in && irq_level_in == 2'b11 |=> !irq_accept_out)
        else $error("level three request taken");
    bank_addr_a: assert property ($past(reset_n_in) |-> gpr_addr_out == CRS_RAM_BASE
        + {8'h00, $past(bank), 3'b000} + {13'h0000, $past(gpr_index_in)})
        else $error("bank register address wrong");
    io_area_a: assert property ($past(reset_n_in) && $past(mem_addr_in) <= CRS_IO_TOP
        |-> mem_area_out == CRS_AREA_IO) else $error("low address not io");
    prog_area_a: assert property ($past(reset_n_in) && $past(mem_addr_in) >= CRS_PROG_BASE
        |-> mem_area_out == CRS_AREA_PROG) else $error("high address not program");
    vector_slot_a: assert property ($past(reset_n_in && admit) |-> vector_addr_out
        == CRS_IRQ_VEC + {13'h0000, $past(irq_level_in), 1'b0}) else $error("vector wrong");
    flag_nz_a: assert property (alu_full_s |=> psw[CRS_BIT_N] == sum_word_out[7]
        && psw[CRS_BIT_Z] == (sum_word_out[7:0] == 8'h00)) else $error("n or z flag wrong");
    flag_hold_a: assert property (alu_hold_s |=> $stable(psw))
        else $error("masked flags changed");
    shift_carry_a: assert property (shl_s |=> psw[CRS_BIT_C] == $past(sum_word_out[7]))
        else $error("shift carry wrong");
    byte_write_a: assert property (dp_wr_en_in && dp_wr_byte_in && dp_wr_sel_in == CRS_SEL_ACC
        |=> sum_word_out[15:8] == $past(sum_word_out[15:8])) else $error("upper byte touched");
endmodule : crs_register_set_checker

bind crs_register_set crs_register_set_checker chk (.*);

// *** tb/crs_datapath_model.sv ***
// execution datapath stand-in: register write strobes and alu steps
`timescale 1ns/1ps
module crs_datapath_model
    import crs_pkg::*;
(
    // clock
    input  wire logic         clk_in,
    // strobes toward the register set
    output logic              dp_wr_en_out,
    output logic [2:0]        dp_wr_sel_out,
    output logic              dp_wr_byte_out,
    output logic [15:0]       dp_wr_data_out,
    output crs_alu_op_t       alu_op_out,
    output logic              alu_carry_in_out,
    output logic [4:0]        alu_flag_we_out
);
    initial
    begin
        dp_wr_en_out     = 1'b0;
        dp_wr_sel_out    = 3'h7;
        dp_wr_byte_out   = 1'b0;
        dp_wr_data_out   = 16'h0000;
        alu_op_out       = CRS_ALU_NONE;
        alu_carry_in_out = 1'b0;
        alu_flag_we_out  = 5'h00;
    end
    // data scrambled after the strobe so a stale word never looks valid
    task automatic wr(input logic [2:0] sel, input logic bsel, input logic [15:0] d);
        @(posedge clk_in);
        dp_wr_en_out   <= 1'b1;
        dp_wr_sel_out  <= sel;
        dp_wr_byte_out <= bsel;
        dp_wr_data_out <= d;
        @(posedge clk_in);
        dp_wr_en_out   <= 1'b0;
        dp_wr_data_out <= ~d;
    endtask : wr
    task automatic step(input crs_alu_op_t op, input logic cin, input logic [4:0] we);
        @(posedge clk_in);
        alu_op_out       <= op;
        alu_carry_in_out <= cin;
        alu_flag_we_out  <= we;
        @(posedge clk_in);
        alu_op_out       <= CRS_ALU_NONE;
    endtask : step
endmodule : crs_datapath_model

// *** tb/crs_register_set_tb.sv ***
// self-checking bench for the register set
`timescale 1ns/1ps
module crs_register_set_tb
    import crs_pkg::*;
();
    logic        clk_in = 1'b0, reset_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, rd_ph = 1'b0;
    logic        irq_valid_in = 1'b0, ram_large_in = 1'b0, hreadyout_out, hresp_out;
    logic        dp_wr_en_in, dp_wr_byte_in, alu_carry_in_in, irq_accept_out;
    logic [31:0] haddr_in = 32'h0000_0000, hwdata_in = 32'h0000_0000, hrdata_out, w;
    logic [1:0]  htrans_in = 2'h0, irq_level_in = 2'h0;
    logic [2:0]  hsize_in = 3'h2, gpr_index_in = 3'h0, dp_wr_sel_in;
    logic [15:0] mem_addr_in = 16'h0000, dp_wr_data_in, program_counter_out, sum_word_out;
    logic [15:0] second_operand_out, index_register_out, extra_pointer_out, stack_pointer_out;
    logic [15:0] program_status_word_out, gpr_addr_out, vector_addr_out;
    logic [4:0]  alu_flag_we_in;
    crs_alu_op_t alu_op_in;
    crs_area_t   mem_area_out;
    wire logic   hready_in = hreadyout_out;
    logic [31:0] exp_q[$], adr_q[$];
    int          err_total = 0, checks_done = 0, cyc = 0;
    crs_alu_op_t ops[8]  = '{CRS_ALU_ADD, CRS_ALU_SUB, CRS_ALU_SHL, CRS_ALU_SHR, CRS_ALU_SUB,
                             CRS_ALU_SUB, CRS_ALU_ADD, CRS_ALU_ADD};
    logic [4:0]  wes[8]  = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h00, 5'h1F, 5'h1F, 5'h1F};
    logic [7:0]  accs[8] = '{8'h10, 8'h88, 8'h11, 8'h88, 8'h00, 8'h78, 8'h00, 8'h89};
    logic [7:0]  psws[8] = '{8'h83, 8'h8B, 8'h83, 8'h8B, 8'h8B, 8'h81, 8'h85, 8'h08};

    crs_register_set uut (.*);
    crs_datapath_model dpm (.clk_in(clk_in), .dp_wr_en_out(dp_wr_en_in),
        .dp_wr_sel_out(dp_wr_sel_in), .dp_wr_byte_out(dp_wr_byte_in),
        .dp_wr_data_out(dp_wr_data_in), .alu_op_out(alu_op_in),
        .alu_carry_in_out(alu_carry_in_in), .alu_flag_we_out(alu_flag_we_in));

    initial
    begin
        forever #10 clk_in = ~clk_in;
    end

    task automatic summarize();
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // single word transfer; for a read d is the expected word
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel_in   <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in  <= a;
        hwrite_in <= wr;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) @(posedge clk_in);
        htrans_in <= 2'h0;
        hwdata_in <= wr ? d : ~hwdata_in;
        rd_ph     <= !wr;
        if (!wr)
        begin
            exp_q.push_back(d);
            adr_q.push_back(a);
        end
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) @(posedge clk_in);
        rd_ph     <= 1'b0;
        hsel_in   <= 1'b0;
        hwdata_in <= ~hwdata_in;
    endtask : bus

    // register output that belongs to a bus select code
    function automatic logic [15:0] port_of(input logic [2:0] s);
        case (s)
            CRS_SEL_PC:  port_of = program_counter_out;
            CRS_SEL_ACC: port_of = sum_word_out;
            CRS_SEL_TMP: port_of = second_operand_out;
            CRS_SEL_IX:  port_of = index_register_out;
            CRS_SEL_EP:  port_of = extra_pointer_out;
            CRS_SEL_SP:  port_of = stack_pointer_out;
            default:     port_of = program_status_word_out;
        endcase
    endfunction : port_of

    always @(posedge clk_in)
    begin
        cyc++;
        if (rd_ph && hreadyout_out === 1'b1)
        begin
            checks_done++;
            if (exp_q[0] !== hrdata_out)
            begin
                err_total++;
                $display("[FAIL] word at %h expected %h seen %h", adr_q[0], exp_q[0], hrdata_out);
            end
            checks_done++;
            if (hresp_out !== 1'b0)
            begin
                err_total++;
                $display("[FAIL] hresp expected 0 seen %b", hresp_out);
            end
            if (adr_q[0] < 32'h0000_001C && adr_q[0][1:0] == 2'h0)
            begin
                checks_done++;
                if (port_of(adr_q[0][4:2]) !== exp_q[0][15:0])
                begin
                    err_total++;
                    $display("[FAIL] port %0d expected %h seen %h", adr_q[0][4:2], exp_q[0][15:0],
                             port_of(adr_q[0][4:2]));
                end
            end
            void'(exp_q.pop_front());
            void'(adr_q.pop_front());
        end
        if (cyc == 6000)
        begin
            err_total++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(59235));
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 8; i++)
            bus(1'b0, 4 * i, i == 6 ? 32'h0000_0030 : i == 7 ? 32'h0100_0000 : 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            w = $urandom;
            bus(1'b1, 4 * i, w);
            bus(1'b0, 4 * i, {16'h0000, w[15:0]});
        end
        bus(1'b1, 32'h0000_0020, 32'hFFFF_FFFF);
        bus(1'b0, 32'h0000_0020, 32'h0000_0000);
        bus(1'b0, 32'h0000_0006, 32'h0000_0000);
        dpm.wr(CRS_SEL_ACC, 1'b0, 16'h5A00);
        dpm.wr(CRS_SEL_ACC, 1'b1, 16'hFF88);
        dpm.wr(CRS_SEL_TMP, 1'b0, 16'h0088);
        dpm.wr(CRS_SEL_PSW, 1'b0, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            dpm.step(ops[i], i == 7, wes[i]);
            bus(1'b0, 32'h0000_0004, {16'h0000, 8'h5A, accs[i]});
            bus(1'b0, 32'h0000_0018, {24'h00_0000, psws[i]});
        end
        mem_addr_in  <= 16'hC000;
        gpr_index_in <= 3'h5;
        irq_valid_in <= 1'b1;
        irq_level_in <= 2'h1;
        bus(1'b1, 32'h0000_0018, 32'h0000_1360);
        bus(1'b0, 32'h0000_001C, 32'h011D_0006);
        irq_level_in <= 2'h2;
        bus(1'b0, 32'h0000_001C, 32'h011D_0002);
        ram_large_in <= 1'b1;
        mem_addr_in  <= 16'h0040;
        bus(1'b0, 32'h0000_001C, 32'h019D_0000);
        repeat (300)
        begin
            @(posedge clk_in);
            {irq_valid_in, irq_level_in, gpr_index_in, ram_large_in, mem_addr_in} <= 23'($urandom);
        end
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        bus(1'b0, 32'h0000_0018, 32'h0000_0030);
        repeat (2) @(posedge clk_in);
        summarize();
    end
endmodule : crs_register_set_tb
